// ===== shared/pcm_conf_pkg.sv
// Purpose: Shared constants and types for the conference slot router
// Assumes: 32-bit Avalon-MM register word, one aligned word per register
// Notes: Offsets are byte addresses

package pcm_conf_pkg;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [4:0] CHANNEL_CONTROL_OFS = 5'h00;
   localparam logic [4:0] CONFERENCE_CONTROL_OFS = 5'h04;
   localparam logic [4:0] GLOBAL_FORMAT_OFS = 5'h08;
   localparam logic [4:0] CONFERENCE_GAIN_OFS = 5'h0c;
   localparam logic [4:0] TX_SLOT_OFS = 5'h10;
   localparam logic [4:0] RX_SLOT_OFS = 5'h14;
   localparam logic [4:0] STATUS_OFS = 5'h18;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int unsigned POWER_DOWN_LSB = 0;
   localparam int unsigned CHAN_SEL_LSB = 4;
   localparam int unsigned LOCAL_CONF_BIT = 0;
   localparam int unsigned REMOTE_CONF_BIT = 1;
   localparam int unsigned LINEAR_BIT = 0;
   localparam int unsigned SLOT_FIELD_STRIDE = 8;
   localparam int unsigned STATUS_LEVEL_LSB = 8;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [3:0] POWER_DOWN_RST = 4'hf;
   localparam logic [1:0] CHAN_SEL_RST = 2'h0;
   localparam logic [1:0] CONF_ENABLE_RST = 2'h0;
   localparam logic LINEAR_RST = 1'b0;
   localparam logic [7:0] GAIN_RST = 8'h40;
   localparam logic [31:0] SLOT_RST = 32'h03020100;

   // ****************************************************************
   // Sizes and arithmetic
   // ****************************************************************
   localparam int unsigned NUM_SLOTS = 4;
   localparam int unsigned SLOT_W = 7;
   localparam int unsigned SAMPLE_W = 16;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned GAIN_SHIFT = 7;
   localparam logic signed [25:0] LIN_MAX = 26'sh0007fff;
   localparam logic signed [25:0] LIN_MIN = -26'sh0008000;
   localparam logic [7:0] ALAW_XOR = 8'h55;

   // ****************************************************************
   // Highway modes
   // ****************************************************************
   typedef enum logic [4:0] {
      MODE_OFF        = 5'b00001,
      MODE_ACTIVE     = 5'b00010,
      MODE_EXT        = 5'b00100,
      MODE_EXT_ACTIVE = 5'b01000,
      MODE_INT        = 5'b10000
   } mode_t;

endpackage

// ===== hdl/sample_fifo.sv
// Purpose: Small synchronous FIFO for subscriber transmit samples
// Assumes: Single clock, active-low reset already synchronised
// Notes: in_ready_o is registered and honest about space

`timescale 1ns/10ps

module sample_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [$clog2(DEPTH+1)-1:0] level_o
);

   localparam int unsigned PW = $clog2(DEPTH);
   localparam int unsigned CW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic ready_reg;
   logic push;
   logic pop;

   // ****************************************************************
   // Flow control
   // ****************************************************************
   assign push = in_valid_i & ready_reg;
   assign pop = out_valid_o & out_ready_i;
   assign out_valid_o = (count_reg != '0);
   assign out_data_o = mem[rd_ptr_reg];
   assign in_ready_o = ready_reg;
   assign level_o = count_reg;

   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
   end

   // ****************************************************************
   // Storage and pointers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         ready_reg <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_next;
         ready_reg <= (count_next < CW'(DEPTH));
      end
   end

endmodule

// ===== hdl/pcm_conference_slot_router.sv
// Purpose: PCM highway slot router with three-party conference mixing
// Assumes: Highway bit clock and frame sync are sampled by clk_i
// Notes: Companded format is A-law; one subscriber channel is served
//
// Overview of operation
// - Per-channel power-down bit, 1 means down
// - All down, no conference: highway stays silent
// - After reset, or power-down without external conference, nothing transmitted
// - Normal mode: to subscriber, subscriber on X1
// - External conference: pairwise gained sums on X2-X4
// - External conference runs with channel powered down
// - External conference plus normal transfer when powered
// - Internal conference mixes B, C and subscriber
// - Format bit: 1 linear, 0 companded
// - Linear sends high then low byte
// - 8-bit companded, 16-bit linear, gained sums

`timescale 1ns/10ps

module pcm_conference_slot_router (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic bclk_i,
   input wire logic fs_i,
   input wire logic dr_i,
   output logic dx_o,
   output logic dx_oe_b_o,
   input wire logic [15:0] s_tx_sample_i,
   input wire logic s_tx_valid_i,
   output logic s_tx_ready_o,
   output logic [15:0] s_rx_sample_o,
   output logic s_rx_valid_o
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] alaw_expand(input logic [7:0] code);
      logic [7:0] ix;
      logic [15:0] t;
      ix = code ^ pcm_conf_pkg::ALAW_XOR;
      t = {8'h00, ix[3:0], 4'h8};
      if (ix[6:4] != 3'h0) begin
         t = (t + 16'h0100) << (ix[6:4] - 3'h1);
      end
      return ix[7] ? t : (16'h0000 - t);
   endfunction

   function automatic logic [7:0] alaw_compress(input logic [15:0] x);
      logic [15:0] mag;
      logic [11:0] m;
      logic [2:0] seg;
      logic [3:0] man;
      mag = x[15] ? ~x : x;
      m = mag[14:3];
      seg = 3'h0;
      for (int i = 0; i < 7; i++) begin
         if (m >= (12'h020 << i)) begin
            seg = 3'(i + 1);
         end
      end
      man = (seg == 3'h0) ? m[4:1] : 4'(m >> seg);
      return {~x[15], seg, man} ^ pcm_conf_pkg::ALAW_XOR;
   endfunction

   function automatic logic [15:0] conf_mix(input logic [15:0] a,
                                            input logic [15:0] b,
                                            input logic [7:0] g);
      logic signed [25:0] sum;
      logic signed [25:0] prod;
      sum = 26'($signed(a)) + 26'($signed(b));
      prod = sum * $signed({18'h00000, g});
      prod = prod >>> pcm_conf_pkg::GAIN_SHIFT;
      if (prod > pcm_conf_pkg::LIN_MAX) begin
         prod = pcm_conf_pkg::LIN_MAX;
      end else if (prod < pcm_conf_pkg::LIN_MIN) begin
         prod = pcm_conf_pkg::LIN_MIN;
      end
      return prod[15:0];
   endfunction

   function automatic logic [15:0] encode(input logic [15:0] w, input logic lin);
      return lin ? w : {alaw_compress(w), 8'h00};
   endfunction

   // ****************************************************************
   // Reset and pin synchronisers
   // ****************************************************************
   logic [1:0] rst_sync_reg;
   logic rst_b;
   logic [2:0] bclk_sync_reg;
   logic [1:0] fs_sync_reg;
   logic [1:0] dr_sync_reg;
   logic bclk_rise;
   logic bclk_fall;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_b = rst_sync_reg[1];

   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         bclk_sync_reg <= 3'h0;
         fs_sync_reg <= 2'h0;
         dr_sync_reg <= 2'h0;
      end else begin
         bclk_sync_reg <= {bclk_sync_reg[1:0], bclk_i};
         fs_sync_reg <= {fs_sync_reg[0], fs_i};
         dr_sync_reg <= {dr_sync_reg[0], dr_i};
      end
   end
   assign bclk_rise = bclk_sync_reg[1] & ~bclk_sync_reg[2];
   assign bclk_fall = ~bclk_sync_reg[1] & bclk_sync_reg[2];

   // ****************************************************************
   // Register file over Avalon-MM
   // ****************************************************************
   logic [3:0] power_down_reg;
   logic [1:0] chan_sel_reg;
   logic local_party_conference_enable;
   logic remote_party_conference_enable;
   logic linear_reg;
   logic [7:0] gain_reg;
   logic [31:0] tx_slot_reg;
   logic [31:0] rx_slot_reg;
   logic wait_reg;
   logic [31:0] channel_control_reg;
   logic [31:0] conference_control_reg;
   logic [31:0] global_format_reg;
   logic [31:0] status_word;
   logic [31:0] rd_mux;
   logic [31:0] wr_val;
   logic wr_fire;
   pcm_conf_pkg::mode_t mode_reg;
   logic [3:0] fifo_level;

   assign channel_control_reg = 32'({chan_sel_reg, power_down_reg});
   assign conference_control_reg = 32'({remote_party_conference_enable,
                                        local_party_conference_enable});
   assign global_format_reg = 32'(linear_reg);
   assign status_word = 32'({fifo_level, 3'h0, mode_reg});
   assign wr_fire = avs_write_i & ~wait_reg;

   always_comb begin
      case (avs_address_i)
         pcm_conf_pkg::CHANNEL_CONTROL_OFS: rd_mux = channel_control_reg;
         pcm_conf_pkg::CONFERENCE_CONTROL_OFS: rd_mux = conference_control_reg;
         pcm_conf_pkg::GLOBAL_FORMAT_OFS: rd_mux = global_format_reg;
         pcm_conf_pkg::CONFERENCE_GAIN_OFS: rd_mux = 32'(gain_reg);
         pcm_conf_pkg::TX_SLOT_OFS: rd_mux = tx_slot_reg;
         pcm_conf_pkg::RX_SLOT_OFS: rd_mux = rx_slot_reg;
         pcm_conf_pkg::STATUS_OFS: rd_mux = status_word;
         default: rd_mux = 32'h00000000;
      endcase
      wr_val = merge_bytes(rd_mux, avs_writedata_i, avs_byteenable_i);
   end

   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         wait_reg <= 1'b1;
         avs_readdata_o <= 32'h00000000;
      end else begin
         wait_reg <= ~((avs_read_i | avs_write_i) & wait_reg);
         if (avs_read_i && wait_reg) begin
            avs_readdata_o <= rd_mux;
         end
      end
   end
   assign avs_waitrequest_o = wait_reg;

   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         power_down_reg <= pcm_conf_pkg::POWER_DOWN_RST;
         chan_sel_reg <= pcm_conf_pkg::CHAN_SEL_RST;
         {remote_party_conference_enable, local_party_conference_enable} <=
            pcm_conf_pkg::CONF_ENABLE_RST;
         linear_reg <= pcm_conf_pkg::LINEAR_RST;
         gain_reg <= pcm_conf_pkg::GAIN_RST;
         tx_slot_reg <= pcm_conf_pkg::SLOT_RST;
         rx_slot_reg <= pcm_conf_pkg::SLOT_RST;
      end else if (wr_fire) begin
         case (avs_address_i)
            pcm_conf_pkg::CHANNEL_CONTROL_OFS: begin
               power_down_reg <= wr_val[pcm_conf_pkg::POWER_DOWN_LSB +: 4];
               chan_sel_reg <= wr_val[pcm_conf_pkg::CHAN_SEL_LSB +: 2];
            end
            pcm_conf_pkg::CONFERENCE_CONTROL_OFS: begin
               local_party_conference_enable <= wr_val[pcm_conf_pkg::LOCAL_CONF_BIT];
               remote_party_conference_enable <= wr_val[pcm_conf_pkg::REMOTE_CONF_BIT];
            end
            pcm_conf_pkg::GLOBAL_FORMAT_OFS: linear_reg <= wr_val[pcm_conf_pkg::LINEAR_BIT];
            pcm_conf_pkg::CONFERENCE_GAIN_OFS: gain_reg <= wr_val[7:0];
            pcm_conf_pkg::TX_SLOT_OFS: tx_slot_reg <= wr_val;
            pcm_conf_pkg::RX_SLOT_OFS: rx_slot_reg <= wr_val;
            default: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // Mode decode
   // ****************************************************************
   pcm_conf_pkg::mode_t mode_next;
   logic sub_down;

   always_comb begin
      sub_down = power_down_reg[chan_sel_reg];
      if (remote_party_conference_enable) begin
         mode_next = sub_down ? pcm_conf_pkg::MODE_EXT
                              : pcm_conf_pkg::MODE_EXT_ACTIVE;
      end else if (local_party_conference_enable && !sub_down) begin
         mode_next = pcm_conf_pkg::MODE_INT;
      end else if (!sub_down) begin
         mode_next = pcm_conf_pkg::MODE_ACTIVE;
      end else begin
         mode_next = pcm_conf_pkg::MODE_OFF;
      end
   end

   // ****************************************************************
   // Subscriber transmit buffer
   // ****************************************************************
   logic [15:0] fifo_data;
   logic fifo_valid;
   logic frame_start;
   logic [15:0] s_cur_reg;
   logic [15:0] s_now;

   sample_fifo #(
      .WIDTH(pcm_conf_pkg::SAMPLE_W),
      .DEPTH(pcm_conf_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_b_i(rst_b),
      .in_data_i(s_tx_sample_i),
      .in_valid_i(s_tx_valid_i),
      .in_ready_o(s_tx_ready_o),
      .out_data_o(fifo_data),
      .out_valid_o(fifo_valid),
      .out_ready_i(frame_start),
      .level_o(fifo_level)
   );
   assign s_now = fifo_valid ? fifo_data : s_cur_reg;

   // ****************************************************************
   // Highway bit and slot position
   // ****************************************************************
   logic [2:0] bit_reg;
   logic [6:0] slot_reg;
   logic [2:0] bit_next;
   logic [6:0] slot_next;
   logic [7:0] shift_reg;
   logic [15:0] rx_word_reg [pcm_conf_pkg::NUM_SLOTS];
   logic [15:0] tx_word_reg [pcm_conf_pkg::NUM_SLOTS];
   logic [3:0] tx_en_reg;

   assign frame_start = bclk_rise & fs_sync_reg[1];

   always_comb begin
      bit_next = bit_reg + 3'h1;
      slot_next = (bit_reg == 3'h7) ? slot_reg + 7'h01 : slot_reg;
      if (fs_sync_reg[1]) begin
         bit_next = 3'h0;
         slot_next = 7'h00;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         bit_reg <= 3'h0;
         slot_reg <= 7'h00;
      end else if (bclk_rise) begin
         bit_reg <= bit_next;
         slot_reg <= slot_next;
      end
   end

   // ****************************************************************
   // Receive slots
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         shift_reg <= 8'h00;
         for (int k = 0; k < pcm_conf_pkg::NUM_SLOTS; k++) begin
            rx_word_reg[k] <= 16'h0000;
         end
      end else if (bclk_fall) begin
         shift_reg <= {shift_reg[6:0], dr_sync_reg[1]};
         if (bit_reg == 3'h7) begin
            for (int k = 0; k < pcm_conf_pkg::NUM_SLOTS; k++) begin
               if (slot_reg == rx_slot_reg[k*pcm_conf_pkg::SLOT_FIELD_STRIDE +: 7]) begin
                  rx_word_reg[k] <= linear_reg
                     ? {shift_reg[6:0], dr_sync_reg[1], rx_word_reg[k][7:0]}
                     : alaw_expand({shift_reg[6:0], dr_sync_reg[1]});
               end else if (linear_reg && slot_reg ==
                  rx_slot_reg[k*pcm_conf_pkg::SLOT_FIELD_STRIDE +: 7] + 7'h01) begin
                  rx_word_reg[k][7:0] <= {shift_reg[6:0], dr_sync_reg[1]};
               end
            end
         end
      end
   end

   // ****************************************************************
   // Frame update: mixing and subscriber output
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         mode_reg <= pcm_conf_pkg::MODE_OFF;
         tx_en_reg <= 4'h0;
         s_cur_reg <= 16'h0000;
         s_rx_sample_o <= 16'h0000;
         s_rx_valid_o <= 1'b0;
         for (int k = 0; k < pcm_conf_pkg::NUM_SLOTS; k++) begin
            tx_word_reg[k] <= 16'h0000;
         end
      end else begin
         s_rx_valid_o <= 1'b0;
         if (frame_start) begin
            mode_reg <= mode_next;
            s_cur_reg <= s_now;
            tx_word_reg[0] <= encode(s_now, linear_reg);
            case (mode_next)
               pcm_conf_pkg::MODE_ACTIVE: begin
                  tx_en_reg <= 4'b0001;
                  s_rx_sample_o <= rx_word_reg[0];
                  s_rx_valid_o <= 1'b1;
               end
               pcm_conf_pkg::MODE_EXT, pcm_conf_pkg::MODE_EXT_ACTIVE: begin
                  tx_word_reg[1] <= encode(conf_mix(rx_word_reg[2], rx_word_reg[3],
                                                    gain_reg), linear_reg);
                  tx_word_reg[2] <= encode(conf_mix(rx_word_reg[1], rx_word_reg[3],
                                                    gain_reg), linear_reg);
                  tx_word_reg[3] <= encode(conf_mix(rx_word_reg[1], rx_word_reg[2],
                                                    gain_reg), linear_reg);
                  if (mode_next == pcm_conf_pkg::MODE_EXT) begin
                     tx_en_reg <= 4'b1110;
                  end else begin
                     tx_en_reg <= 4'b1111;
                     s_rx_sample_o <= rx_word_reg[0];
                     s_rx_valid_o <= 1'b1;
                  end
               end
               pcm_conf_pkg::MODE_INT: begin
                  tx_en_reg <= 4'b0110;
                  tx_word_reg[1] <= encode(conf_mix(rx_word_reg[2], s_now, gain_reg),
                                           linear_reg);
                  tx_word_reg[2] <= encode(conf_mix(rx_word_reg[1], s_now, gain_reg),
                                           linear_reg);
                  s_rx_sample_o <= conf_mix(rx_word_reg[1], rx_word_reg[2], gain_reg);
                  s_rx_valid_o <= 1'b1;
               end
               default: begin
                  tx_en_reg <= 4'b0000;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Transmit slots X1 to X4 and line driver
   // ****************************************************************
   logic tx_hit;
   logic tx_bit;
   logic [6:0] tx_base;

   always_comb begin
      tx_hit = 1'b0;
      tx_bit = 1'b0;
      for (int k = pcm_conf_pkg::NUM_SLOTS - 1; k >= 0; k--) begin
         tx_base = tx_slot_reg[k*pcm_conf_pkg::SLOT_FIELD_STRIDE +: 7];
         if (tx_en_reg[k] && slot_next == tx_base) begin
            tx_hit = 1'b1;
            tx_bit = tx_word_reg[k][4'd15 - {1'b0, bit_next}];
         end else if (tx_en_reg[k] && linear_reg && slot_next == tx_base + 7'h01) begin
            tx_hit = 1'b1;
            tx_bit = tx_word_reg[k][3'd7 - bit_next];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         dx_o <= 1'b0;
         dx_oe_b_o <= 1'b1;
      end else if (bclk_rise) begin
         dx_o <= tx_hit & tx_bit;
         dx_oe_b_o <= ~tx_hit;
      end
   end

endmodule

// ===== verification/pcm_highway_model.sv
// Purpose: Far-side highway: bit clock, frame sync, receive data
// Assumes: 160 ns bit period, 64 bits a frame
// Notes: Clock stands still between frames while run_i is low
`timescale 1ns/10ps
module pcm_highway_model (
   input wire logic run_i,
   output logic bclk_o,
   output logic fs_o,
   output logic dr_o
);
   int bit_n = 0;
   initial begin
      bclk_o = 1'b0;
      fs_o = 1'b0;
      dr_o = 1'b1;
      forever begin
         if (bit_n == 0 && run_i !== 1'b1) begin
            wait (run_i === 1'b1);
            #3;
         end
         fs_o = (bit_n == 0);
         #80 bclk_o = 1'b1;
         dr_o = 1'($urandom);
         #80 bclk_o = 1'b0;
         bit_n = (bit_n + 1) % 64;
      end
   end
endmodule

// ===== verification/pcm_conference_slot_router_chk.sv
// Purpose: Port assertions for the slot router
// Assumes: Bound to the top module
// Notes: One clock domain
`timescale 1ns/10ps
module pcm_conference_slot_router_chk (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic fs_i,
   input wire logic dx_o,
   input wire logic dx_oe_b_o,
   input wire logic s_tx_ready_o,
   input wire logic s_rx_valid_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   a_wait_gap: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("Wait low too long");
   a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |-> ##[0:2] !avs_waitrequest_o) else $error("No answer");
   a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
      && avs_address_i > 5'h18 |-> avs_readdata_o == 32'h0) else $error("Unmapped read");
   a_status_onehot: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 5'h18
      |-> avs_readdata_o[31:12] == 20'h0 && $onehot(avs_readdata_o[4:0])) else $error("Mode");
   a_quiet_line: assert property (dx_oe_b_o |-> !dx_o)
      else $error("Data while off");
   a_rx_frame: assert property (s_rx_valid_o |-> $past(fs_i, 4) ##1 !s_rx_valid_o)
      else $error("Pulse off frame");
   a_slot_length: assert property ($fell(dx_oe_b_o) |-> !dx_oe_b_o [*8])
      else $error("Slot short");
   a_ready_reset: assert property ($rose(rst_b_i) |-> !s_tx_ready_o [*3])
      else $error("Ready early");
   a_reset_silent: assert property ($rose(rst_b_i) |-> dx_oe_b_o [*8])
      else $error("Drive after reset");
   cover property (!dx_oe_b_o);
   cover property (s_rx_valid_o);
   cover property (avs_write_i && !avs_waitrequest_o);
endmodule
bind pcm_conference_slot_router pcm_conference_slot_router_chk u_pcm_conference_slot_router_chk (
   .clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
   .avs_waitrequest_o, .fs_i, .dx_o, .dx_oe_b_o, .s_tx_ready_o, .s_rx_valid_o);

// ===== verification/pcm_conference_slot_router_test.sv
// Purpose: Self-checking bench for the slot router
// Assumes: Highway model frames only while run is high
// Notes: Seed 62
`timescale 1ns/10ps
module pcm_conference_slot_router_test;
   logic clk_i = 0, rst_b = 0, rd = 0, wr = 0, sv = 0, run = 0;
   logic [4:0] ad = 0, m;
   logic [31:0] wd = 0, q, rdat;
   logic [15:0] sd = 0, rs;
   logic [15:0] xw, xr, xp, xs, s_last;
   logic [7:0] g;
   logic bclk, fs, dr, dx, oe_b, rdy, wq, rv, p;
   int n_fail = 0, check_count = 0, cyc = 0, lo, pu, n;
   pcm_highway_model u_pcm_highway_model (.run_i(run), .bclk_o(bclk), .fs_o(fs), .dr_o(dr));
   pcm_conference_slot_router u_pcm_conference_slot_router (.clk_i(clk_i), .rst_b_i(rst_b),
      .avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .bclk_i(bclk),
      .fs_i(fs), .dr_i(dr), .dx_o(dx), .dx_oe_b_o(oe_b), .s_tx_sample_i(sd),
      .s_tx_valid_i(sv), .s_tx_ready_o(rdy), .s_rx_sample_o(rs), .s_rx_valid_o(rv));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   always @(negedge bclk) begin
      xw <= {xw[14:0], dx};
      xr <= {xr[14:0], dr};
   end
   task automatic complete_run();
      $display("Checks %0d, failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] gv, input logic [31:0] e);
      check_count++;
      if (gv !== e) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h exp %h", $time, gv, e);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      ad <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      @(posedge clk_i);
      while (wq !== 1'b0) @(posedge clk_i);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] e);
      bus(0, a, 0);
      chk(q, e);
   endtask
   task automatic frame();
      @(posedge fs);
      repeat (261) @(posedge clk_i);
      xp = xr;
      @(posedge fs);
      lo = 0;
      pu = 0;
      for (int k = 0; k < 1024; k++) begin
         @(posedge clk_i);
         lo += (oe_b === 1'b0);
         pu += (rv === 1'b1);
         if (k == 260) xs = xw;
      end
   endtask
   function automatic logic [4:0] mode_of(input logic pd, input logic [1:0] cf);
      if (cf[1]) return pd ? pcm_conf_pkg::MODE_EXT : pcm_conf_pkg::MODE_EXT_ACTIVE;
      if (cf[0] && !pd) return pcm_conf_pkg::MODE_INT;
      return pd ? pcm_conf_pkg::MODE_OFF : pcm_conf_pkg::MODE_ACTIVE;
   endfunction
   initial begin
      void'($urandom(62));
      repeat (8) @(posedge clk_i);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_i);
      rdc(5'h00, 32'h0000000f);
      rdc(5'h04, 32'h0);
      rdc(5'h08, 32'h0);
      rdc(5'h14, 32'h03020100);
      g = 8'($urandom);
      bus(1, 5'h0c, {24'h0, g});
      rdc(5'h0c, {24'h0, g});
      bus(1, 5'h1c, 32'hffffffff);
      rdc(5'h1c, 32'h0);
      bus(1, 5'h10, 32'h06040200);
      n = 0;
      sv <= 1'b1;
      repeat (12) begin
         sd <= 16'($urandom);
         @(posedge clk_i);
         n += (rdy === 1'b1);
         if (rdy === 1'b1) s_last = sd;
      end
      sv <= 1'b0;
      chk(n, 8);
      bus(1, 5'h18, 32'h0);
      rdc(5'h18, 32'h00000801);
      run <= 1'b1;
      frame();
      chk(lo + pu, 0);
      for (int i = 0; i < 16; i++) begin
         p = i[2] && (i[1:0] != 2'b01);
         bus(1, 5'h08, {31'h0, i[3]});
         bus(1, 5'h00, {28'h0, 3'h7, p});
         bus(1, 5'h04, {30'h0, i[1:0]});
         m = mode_of(p, i[1:0]);
         frame();
         if (i[3] && (m[1] || m[3])) begin
            chk(xs, s_last);
            chk(rs, xp);
         end
         bus(0, 5'h18, 0);
         chk(q & 32'h1f, m);
         n = m[1] + 3 * m[2] + 4 * m[3] + 2 * m[4];
         chk((lo + 8) / 16, n * 8 * (i[3] + 1));
         chk(pu, m[1] | m[3] | m[4]);
      end
      rdc(5'h18, {27'h0, pcm_conf_pkg::MODE_EXT});
      complete_run();
   end
endmodule
